// *** verilog/pbw_pkg.sv ***
package pbw_pkg;
  // Clock rate and documented times.
  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned DEBOUNCE_MS = 8;
  localparam int unsigned AUTOSCAN_HOLD_MS = 1000;
  localparam int unsigned AUTOSCAN_STEP_MS = 140;
  localparam int unsigned AUTOSAVE_IDLE_MS = 1000;
  localparam int unsigned SAVE_LOCK_MS = 20;
  // Cycle counts derived from the times above.
  localparam int unsigned DEBOUNCE_CYC = (CLK_HZ / 1000) * DEBOUNCE_MS + 1;
  localparam int unsigned AUTOSCAN_HOLD_CYC =
    (CLK_HZ / 1000) * AUTOSCAN_HOLD_MS + 1;
  localparam int unsigned AUTOSCAN_STEP_CYC =
    (CLK_HZ / 1000) * AUTOSCAN_STEP_MS;
  localparam int unsigned AUTOSAVE_IDLE_CYC =
    (CLK_HZ / 1000) * AUTOSAVE_IDLE_MS;
  localparam int unsigned SAVE_LOCK_CYC = (CLK_HZ / 1000) * SAVE_LOCK_MS;
  // Wiper code layout: 6-bit code plus the two extra end positions.
  localparam int unsigned CODE_W = 6;
  localparam logic [1:0] SCALE_NORMAL = 2'h0;
  localparam logic [1:0] SCALE_BOTTOM = 2'h1;
  localparam logic [1:0] SCALE_TOP = 2'h2;
  localparam logic [CODE_W-1:0] CODE_ZERO = 6'h00;
  localparam logic [CODE_W-1:0] CODE_FULL = 6'h3f;
  localparam logic [CODE_W-1:0] CODE_MID = 6'h20;
  localparam int unsigned TMR_W = 32;
  // Per-button press tracker states.
  typedef enum logic [1:0] {
    PBW_BTN_IDLE = 2'b00,
    PBW_BTN_DEB = 2'b01,
    PBW_BTN_HELD = 2'b10,
    PBW_BTN_SCAN = 2'b11
  } pbw_btn_state_t;
endpackage

// *** verilog/pbw_press.sv ***
module pbw_press
  import pbw_pkg::*;
#(
  parameter int unsigned DEB_CYC = pbw_pkg::DEBOUNCE_CYC,
  parameter int unsigned HOLD_CYC = pbw_pkg::AUTOSCAN_HOLD_CYC,
  parameter int unsigned STEP_CYC = pbw_pkg::AUTOSCAN_STEP_CYC
)
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic btn_i,
  input wire logic lock_i,
  output logic step_o,
  output logic valid_o
);
  pbw_btn_state_t state_q, state_d;
  logic [TMR_W-1:0] tmr_q, tmr_d;

  // Debounce, single step, then auto-scan while the press is held.
  always_comb
  begin
    state_d = state_q;
    tmr_d = tmr_q + 32'h1;
    step_o = 1'b0;
    if (!btn_i || lock_i)
    begin
      state_d = PBW_BTN_IDLE; // [RULE1] [RULE19]
      tmr_d = '0;
    end
    else
    begin
      unique case (state_q)
        PBW_BTN_IDLE:
        begin
          state_d = PBW_BTN_DEB;
          tmr_d = 32'h1;
        end
        PBW_BTN_DEB:
          if (tmr_q >= DEB_CYC[TMR_W-1:0])
          begin
            state_d = PBW_BTN_HELD;
            step_o = 1'b1; // [RULE2]
          end
        PBW_BTN_HELD:
          if (tmr_q >= HOLD_CYC[TMR_W-1:0])
          begin
            state_d = PBW_BTN_SCAN; // [RULE3]
            step_o = 1'b1;
            tmr_d = 32'h1;
          end
        PBW_BTN_SCAN:
          if (tmr_q >= STEP_CYC[TMR_W-1:0])
          begin
            step_o = 1'b1; // [RULE4]
            tmr_d = 32'h1;
          end
      endcase
    end
  end

  // Press tracker registers.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_q <= PBW_BTN_IDLE;
      tmr_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      tmr_q <= tmr_d;
    end
  end

  assign valid_o = (state_q == PBW_BTN_HELD) || (state_q == PBW_BTN_SCAN);
endmodule

// *** verilog/pbw_stepper.sv ***
// Notes on behaviour
// [RULE1] Up highs shorter than 8 ms ignored.
// [RULE2] Up high beyond 8 ms steps once.
// [RULE3] Up held over 1 s enters auto-scan.
// [RULE4] Auto-scan steps every 140 ms until release.
// [RULE5] Down button mirrors up, decrementing.
// [RULE6] Buttons active high; low means idle.
// [RULE7] Code 0x20 selects midscale tap.
// [RULE8] Extra bottom and top positions beyond ends.
// [RULE9] Bottom scale holds against further down steps.
// [RULE10] Top scale holds against further up steps.
// [RULE11] Buttons ignored during nonvolatile save.
// [RULE12] Power-up loads last saved position.
// [RULE13] Autosave pin sampled at power-up, active low.
// [RULE14] Autosave pin signals end of scale.
// [RULE15] Autosave after one idle second.
// [RULE16] Manual save when pin low over 8 ms.
// [RULE17] End pin high while button active there.
// [RULE18] Position is a 6-bit tap code.
// [RULE19] Release clears hold timer, restarts debounce.
module pbw_stepper
  import pbw_pkg::*;
#(
  parameter int unsigned DEB_CYC = pbw_pkg::DEBOUNCE_CYC,
  parameter int unsigned HOLD_CYC = pbw_pkg::AUTOSCAN_HOLD_CYC,
  parameter int unsigned STEP_CYC = pbw_pkg::AUTOSCAN_STEP_CYC,
  parameter int unsigned IDLE_CYC = pbw_pkg::AUTOSAVE_IDLE_CYC,
  parameter int unsigned LOCK_CYC = pbw_pkg::SAVE_LOCK_CYC
)
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic step_up_button_i,
  input wire logic step_down_button_i,
  input wire logic autosave_enable_n_i,
  output logic autosave_enable_n_o,
  output logic autosave_enable_n_oe,
  input wire logic [pbw_pkg::CODE_W-1:0] nvm_code_i,
  input wire logic [1:0] nvm_scale_i,
  output logic [pbw_pkg::CODE_W-1:0] wiper_position_register_o,
  output logic bottom_scale_step_o,
  output logic top_scale_step_o,
  output logic nvm_write_o,
  output logic [pbw_pkg::CODE_W-1:0] nvm_code_o,
  output logic [1:0] nvm_scale_o,
  output logic locked_o,
  output logic autosave_on_o
);
  logic rst_s1_q, rst_n_q;
  logic started_q, started_d;
  logic auto_q, auto_d;
  logic [CODE_W-1:0] code_q, code_d;
  logic [1:0] scale_q, scale_d;
  logic [TMR_W-1:0] idle_q, idle_d;
  logic [TMR_W-1:0] lock_q, lock_d;
  logic lock_on_q, lock_on_d;
  logic wr_q, wr_d;
  logic oe_q, oe_d;
  logic [1:0] btn;
  logic [1:0] step;
  logic [1:0] valid;
  logic man_valid, man_q, man_d;
  logic man_req;
  logic bot_q, bot_d, top_q, top_d, drv_q, drv_d;

  // Reset release through two flip-flops.
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  assign btn[0] = step_up_button_i; // [RULE6]
  assign btn[1] = step_down_button_i;
  // Manual save input is the active-low pin, only when autosave is off.
  assign man_req = !auto_q && started_q && !autosave_enable_n_i;

  // One press tracker per button, plus one for the manual save pin.
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : gen_btn
      pbw_press #(
        .DEB_CYC(DEB_CYC),
        .HOLD_CYC(HOLD_CYC),
        .STEP_CYC(STEP_CYC)
      ) u_press (
        .clk_i(clk_i),
        .rst_n_i(rst_n_q),
        .btn_i(btn[g]),
        .lock_i(lock_on_q), // [RULE11]
        .step_o(step[g]), // [RULE5]
        .valid_o(valid[g])
      );
    end
  endgenerate

  pbw_press #(
    .DEB_CYC(DEB_CYC),
    .HOLD_CYC(HOLD_CYC),
    .STEP_CYC(STEP_CYC)
  ) u_man (
    .clk_i(clk_i),
    .rst_n_i(rst_n_q),
    .btn_i(man_req),
    .lock_i(lock_on_q),
    .step_o(),
    .valid_o(man_valid) // [RULE16]
  );

  // Wiper position, saving and end-of-scale indication.
  always_comb
  begin
    started_d = 1'b1;
    auto_d = auto_q;
    code_d = code_q;
    scale_d = scale_q;
    idle_d = idle_q;
    lock_d = lock_q;
    lock_on_d = lock_on_q;
    wr_d = 1'b0;
    oe_d = oe_q;
    man_d = man_valid;
    if (!started_q)
    begin
      auto_d = !autosave_enable_n_i; // [RULE13]
      code_d = nvm_code_i; // [RULE12]
      scale_d = nvm_scale_i;
      idle_d = '0;
    end
    else if (lock_on_q)
    begin
      // Count out the save time; buttons are held off meanwhile.
      if (lock_q >= LOCK_CYC[TMR_W-1:0] - 32'h1)
      begin
        lock_on_d = 1'b0; // [RULE11]
        lock_d = '0;
      end
      else
      begin
        lock_d = lock_q + 32'h1;
      end
      // Idle time is kept, so one quiet spell leads to one save only.
    end
    else
    begin
      if (step[0])
      begin
        if (scale_q == SCALE_BOTTOM)
          scale_d = SCALE_NORMAL;
        else if (scale_q == SCALE_NORMAL && code_q == CODE_FULL)
          scale_d = SCALE_TOP; // [RULE8]
        else if (scale_q == SCALE_NORMAL)
          code_d = code_q + 6'h01; // [RULE18]
        // Top scale: no change. [RULE10]
      end
      else if (step[1])
      begin
        if (scale_q == SCALE_TOP)
          scale_d = SCALE_NORMAL;
        else if (scale_q == SCALE_NORMAL && code_q == CODE_ZERO)
          scale_d = SCALE_BOTTOM; // [RULE8]
        else if (scale_q == SCALE_NORMAL)
          code_d = code_q - 6'h01;
        // Bottom scale: no change. [RULE9]
      end
      // Idle timer restarts on any button activity.
      if (btn[0] || btn[1])
        idle_d = '0;
      else if (idle_q < IDLE_CYC[TMR_W-1:0])
        idle_d = idle_q + 32'h1;
      if (auto_q && idle_q == IDLE_CYC[TMR_W-1:0] - 32'h1)
      begin
        wr_d = 1'b1; // [RULE15]
        lock_on_d = 1'b1;
        idle_d = IDLE_CYC[TMR_W-1:0];
      end
      else if (man_valid && !man_q)
      begin
        wr_d = 1'b1; // [RULE16]
        lock_on_d = 1'b1;
      end
    end
    // In autosave mode only, end pin high while at an end with a button pressed into it.
    oe_d = auto_q && started_q &&
           ((scale_d == SCALE_TOP && btn[0]) ||
            (scale_d == SCALE_BOTTOM && btn[1])); // [RULE14] [RULE17]
    // End flags and the pin drive level are registered outputs.
    bot_d = scale_d == SCALE_BOTTOM; // [RULE8]
    top_d = scale_d == SCALE_TOP;
    drv_d = 1'b1;
  end

  // Position and control registers.
  always_ff @(posedge clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      started_q <= 1'b0;
      auto_q <= 1'b0;
      code_q <= CODE_MID; // [RULE7]
      scale_q <= SCALE_NORMAL;
      idle_q <= '0;
      lock_q <= '0;
      lock_on_q <= 1'b0;
      wr_q <= 1'b0;
      oe_q <= 1'b0;
      man_q <= 1'b0;
      bot_q <= 1'b0;
      top_q <= 1'b0;
      drv_q <= 1'b1;
    end
    else
    begin
      started_q <= started_d;
      auto_q <= auto_d;
      code_q <= code_d;
      scale_q <= scale_d;
      idle_q <= idle_d;
      lock_q <= lock_d;
      lock_on_q <= lock_on_d;
      wr_q <= wr_d;
      oe_q <= oe_d;
      man_q <= man_d;
      bot_q <= bot_d;
      top_q <= top_d;
      drv_q <= drv_d;
    end
  end

  assign wiper_position_register_o = code_q;
  assign bottom_scale_step_o = bot_q;
  assign top_scale_step_o = top_q;
  assign nvm_write_o = wr_q;
  assign nvm_code_o = code_q;
  assign nvm_scale_o = scale_q;
  assign locked_o = lock_on_q;
  assign autosave_on_o = auto_q;
  assign autosave_enable_n_o = drv_q;
  assign autosave_enable_n_oe = oe_q;
endmodule

// *** dv/pbw_stepper_monitor.sv ***
module pbw_stepper_chk
  import pbw_pkg::*;
#(
  parameter int unsigned DEB_CYC = pbw_pkg::DEBOUNCE_CYC
)
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic step_up_button_i,
  input wire logic step_down_button_i,
  input wire logic autosave_enable_n_oe,
  input wire logic [pbw_pkg::CODE_W-1:0] wiper_position_register_o,
  input wire logic bottom_scale_step_o,
  input wire logic top_scale_step_o,
  input wire logic nvm_write_o,
  input wire logic locked_o,
  input wire logic autosave_on_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // All checks run on the one clock and rest while reset is low.
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  lock_follows_a: assert property (nvm_write_o |=> locked_o)
    else $error("no lock after save");
  lock_still_a: assert property (locked_o |->
    $stable(wiper_position_register_o))
    else $error("wiper moved while locked");
  up_step_a: assert property (!$stable(wiper_position_register_o) &&
    $past(step_up_button_i) |-> wiper_position_register_o ==
    $past(wiper_position_register_o) + 6'h1) else $error("bad up step");
  down_step_a: assert property (!$stable(wiper_position_register_o) &&
    $past(step_down_button_i) |-> wiper_position_register_o ==
    $past(wiper_position_register_o) - 6'h1) else $error("bad down step");
  deb_time_a: assert property (!$stable(wiper_position_register_o) &&
    $past(step_up_button_i || step_down_button_i) |->
    $past(step_up_button_i || step_down_button_i, DEB_CYC))
    else $error("step without debounce");
  top_hold_a: assert property (top_scale_step_o &&
    step_up_button_i |=> top_scale_step_o &&
    wiper_position_register_o == CODE_FULL) else $error("left top scale");
  bottom_hold_a: assert property (bottom_scale_step_o &&
    step_down_button_i |=> bottom_scale_step_o &&
    wiper_position_register_o == CODE_ZERO)
    else $error("left bottom scale");
  end_pin_a: assert property (autosave_on_o && top_scale_step_o &&
    step_up_button_i |=> autosave_enable_n_oe) else $error("no end pin");
  pin_quiet_a: assert property (!autosave_on_o |->
    !autosave_enable_n_oe) else $error("pin driven in manual mode");
  cover property (locked_o ##1 !locked_o);
  cover property (top_scale_step_o && autosave_enable_n_oe);
  cover property (bottom_scale_step_o ##1 !bottom_scale_step_o);
endmodule

bind pbw_stepper pbw_stepper_chk #(.DEB_CYC(DEB_CYC)) chk_u (.*);

// *** dv/pbw_buttons.sv ***
module pbw_buttons
(
  input wire logic up_press_i,
  input wire logic down_press_i,
  input wire logic save_press_i,
  input wire logic strap_low_i,
  input wire logic pin_oe_i,
  input wire logic pin_drv_i,
  output logic up_o,
  output logic down_o,
  output logic pin_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Closed switches pull high; the pull-downs hold open ones low.
  assign up_o = up_press_i;
  assign down_o = down_press_i;
  // Device drive wins, else the save switch, else the strap resistor.
  assign pin_o = pin_oe_i ? pin_drv_i : !(save_press_i || strap_low_i);
endmodule

// *** dv/test_pushbutton_wiper_stepper.sv ***
module test_pushbutton_wiper_stepper;
  timeunit 1ns;
  timeprecision 1ns;
  import pbw_pkg::*;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic up_press = 1'b0;
  logic down_press = 1'b0;
  logic save_press = 1'b0;
  logic strap_low = 1'b0;
  logic [5:0] nvm_code = 6'h20;
  logic [1:0] nvm_scale = 2'h0;
  logic up_b, down_b, pin, pin_oe, pin_drv, wr, lk, aon, bot, top;
  logic [5:0] wiper, ncode;
  logic [1:0] nscale;
  int num_errors = 0;
  int check_count = 0;

  pbw_buttons btn_u (.up_press_i(up_press), .down_press_i(down_press),
    .save_press_i(save_press), .strap_low_i(strap_low), .pin_oe_i(pin_oe),
    .pin_drv_i(pin_drv), .up_o(up_b), .down_o(down_b), .pin_o(pin));
  pbw_stepper #(.DEB_CYC(8), .HOLD_CYC(40), .STEP_CYC(14), .IDLE_CYC(50),
    .LOCK_CYC(20)) dut_u (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .step_up_button_i(up_b), .step_down_button_i(down_b),
    .autosave_enable_n_i(pin), .autosave_enable_n_o(pin_drv),
    .autosave_enable_n_oe(pin_oe), .nvm_code_i(nvm_code),
    .nvm_scale_i(nvm_scale), .wiper_position_register_o(wiper),
    .bottom_scale_step_o(bot), .top_scale_step_o(top), .nvm_write_o(wr),
    .nvm_code_o(ncode), .nvm_scale_o(nscale), .locked_o(lk),
    .autosave_on_o(aon));

  // Free-running 50 MHz clock.
  initial
  begin
    forever #10 clk_i = ~clk_i;
  end

  task chk(input logic [7:0] seen, input logic [7:0] want, input string what);
    check_count++;
    if (seen !== want)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, want, seen);
    end
  endtask

  task stop_test;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Power cycle with a strap level and a stored position.
  task power_up(input logic low, input logic [5:0] code);
    @(posedge clk_i);
    reset_n_i <= 1'b0;
    strap_low <= low;
    nvm_code <= code;
    cyc(16);
    reset_n_i <= 1'b1;
    cyc(4);
    @(negedge clk_i);
    chk(wiper, code, "restored");
    chk(aon, low, "mode");
  endtask

  // Holds one button for n cycles, then leaves both open for gap cycles.
  task press(input logic up, input int n, input int gap);
    @(posedge clk_i);
    up_press <= up;
    down_press <= !up;
    cyc(n);
    up_press <= 1'b0;
    down_press <= 1'b0;
    cyc(gap);
    @(negedge clk_i);
  endtask

  task wait_write(input string what);
    int i;
    i = 0;
    do @(negedge clk_i); while (wr !== 1'b1 && ++i < 200);
    chk(wr, 1'b1, what);
  endtask

  task t_debounce;
    power_up(1'b0, 6'h20);
    repeat (3) press(1'b1, 6, 2);
    repeat (3) press(1'b0, 6, 2);
    chk(wiper, 6'h20, "bounce");
    press(1'b1, 12, 4);
    chk(wiper, 6'h21, "up");
    press(1'b0, 12, 4);
    chk(wiper, 6'h20, "down");
  endtask

  task t_scan;
    power_up(1'b0, 6'h10);
    press(1'b1, 78, 4);
    chk(wiper, 6'h14, "scan up");
    press(1'b1, 20, 4);
    chk(wiper, 6'h15, "new press");
    press(1'b0, 78, 4);
    chk(wiper, 6'h11, "scan down");
  endtask

  task t_ends;
    power_up(1'b1, 6'h3e);
    @(posedge clk_i);
    up_press <= 1'b1;
    cyc(70);
    @(negedge clk_i);
    chk({top, wiper}, 7'h7f, "top");
    chk(pin, 1'b1, "end pin");
    press(1'b0, 12, 4);
    chk({top, wiper}, 7'h3f, "off top");
    power_up(1'b1, 6'h01);
    press(1'b0, 70, 4);
    chk({bot, wiper}, 7'h40, "bottom");
    press(1'b1, 12, 4);
    chk({bot, wiper}, 7'h00, "off bottom");
  endtask

  task t_autosave;
    logic [7:0] saves;
    saves = 8'h0;
    power_up(1'b1, 6'h20);
    press(1'b1, 12, 0);
    wait_write("autosave");
    chk(lk, 1'b1, "lock on");
    chk(ncode, 6'h21, "saved");
    chk(nscale, 2'h0, "saved scale");
    press(1'b1, 15, 0);
    chk(wiper, 6'h21, "locked");
    // A quiet spell after the save must not lead to a second write.
    repeat (80) @(negedge clk_i) if (wr) saves = saves + 8'h1;
    chk(saves, 8'h0, "one save");
  endtask

  task t_manual;
    power_up(1'b0, 6'h07);
    @(posedge clk_i);
    save_press <= 1'b1;
    wait_write("manual");
    @(posedge clk_i);
    save_press <= 1'b0;
    chk(ncode, 6'h07, "saved");
  endtask

  // Main sequence.
  initial
  begin
    t_debounce;
    t_scan;
    t_ends;
    t_autosave;
    t_manual;
    stop_test;
  end

  // Watchdog against a hang.
  initial
  begin
    cyc(20000);
    num_errors++;
    stop_test;
  end
endmodule
